// ### inc/pcs_pkg.sv
/*
  Shared constants for the power-up clock startup block: generator and
  multiplexer counts, startup reset values and configuration port layout.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcs_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int NUM_GEN  = 8;
  localparam int NUM_MUX  = 4;
  localparam int NUM_IO   = 8;
  localparam int NUM_SRC  = 8;
  localparam int DIV_W    = 8;
  localparam int SEL_W    = 3;

  // ----------------------------------------------------------------
  // startup values
  // ----------------------------------------------------------------
  localparam int OSC_MHZ  = 8;
  localparam int MAIN_MHZ = 1;
  localparam logic [DIV_W-1:0] GEN0_DIV_RST = DIV_W'(OSC_MHZ / MAIN_MHZ);
  localparam logic [SEL_W-1:0] GEN0_SRC_RST = 3'h0;
  localparam logic [NUM_GEN-1:0] GEN_EN_RST  = 8'h01;
  localparam logic [NUM_GEN-1:0] GEN_DIV_RST = 8'h01;
  localparam int WATCHDOG_MUX = 0;
  localparam logic [NUM_MUX-1:0] MUX_EN_RST  = 4'h1;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;

  // ----------------------------------------------------------------
  // configuration port layout
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_GEN_BASE = 4'h0;
  localparam logic [3:0] CFG_MUX_BASE = 4'h8;
  localparam logic [3:0] CFG_IO       = 4'hC;
  localparam int F_SRC    = 0;
  localparam int F_EN     = 3;
  localparam int F_DIVEN  = 4;
  localparam int F_DIV    = 8;
  localparam int F_IO_OUT = 0;
  localparam int F_IO_OE  = 8;

  // ----------------------------------------------------------------
  // startup sequence
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_HOLD = 4'b0001,
    S_FSP  = 4'b0010,
    S_FPC  = 4'b0100,
    S_RUN  = 4'b1000
  } pcs_state_e;

endpackage

// ### src/pcs_gen.sv
/*
  One clock generator: passes its source tick straight through or divides it.
  Assumes source ticks are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps
module pcs_gen (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // source and setup
  input  wire logic                       src_tick,
  input  wire logic                       enable,
  input  wire logic                       div_en,
  input  wire logic [pcs_pkg::DIV_W-1:0]  div,
  // output
  output logic                            tick_q
);

  logic [pcs_pkg::DIV_W-1:0] cnt_q;
  logic                      pass;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign pass = !div_en || (div <= pcs_pkg::DIV_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (!enable) begin
        cnt_q <= '0;
      end else if (src_tick) begin
        if (pass) begin
          tick_q <= 1'b1;                                     // see RL13
          cnt_q  <= '0;
        end else if (cnt_q == div - pcs_pkg::DIV_W'(1)) begin
          tick_q <= 1'b1;                                     // see RL13
          cnt_q  <= '0;
        end else begin
          cnt_q <= cnt_q + pcs_pkg::DIV_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_gen_passthru: assert property (@(posedge clk) disable iff (rst)    // see RL13
    ce && enable && src_tick && !div_en |=> tick_q)
    else $error("direct generator dropped a source tick");

  a_gen_no_src: assert property (@(posedge clk) disable iff (rst)      // see RL13
    ce && !(enable && src_tick) |=> !tick_q)
    else $error("generator ticked without a source tick");

endmodule

// ### src/pcs_top.sv
/*
  Power-up clock startup and generic clock controller core: reset hold,
  initial vector fetch, eight generators feeding clock multiplexers,
  I/O tri-state at startup and write-protected configuration.
  Assumes clocks are carried as one-cycle ticks synchronous to clk and that
  the power manager, access controller and debugger drive plain levels.
*/
// Functional notes
// RL1 - until power is reported stable the block keeps itself in its initial state with reset asserted.
// RL2 - once power is stable generator 0 divides the 8MHz oscillator by eight to give 1MHz.
// RL3 - generator 0 is the main clock of the power manager.
// RL4 - running system clocks are undivided and take the 1MHz clock from generator 0.
// RL5 - after power-up every peripheral clock is off except the watchdog clock.
// RL6 - after power-up all I/O pins are high impedance.
// RL7 - on reset release the processor fetches stack pointer and start address from address zero.
// RL8 - configuration access needs the bus clock that the power manager enables.
// RL9 - every configuration write may be blocked by the access controller's protection.
// RL10 - protection is lifted while the processor is halted in debug.
// RL11 - protection never blocks external debugger accesses.
// RL12 - there are eight generators sourcing a set of clock multiplexers.
// RL13 - each generator passes its source directly or prescales it.
// RL14 - a generator may feed several multiplexers and each multiplexer clocks its peripherals.
`timescale 1ns/1ps
module pcs_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // power manager
  input  wire logic                        power_stable,
  input  wire logic                        power_manager_bus_clk_en,
  output logic                             sys_rst_q,
  output logic                             power_manager_clk_tick,
  output logic                             sys_clk_tick,
  // clock sources, source 0 is the internal oscillator
  input  wire logic                        internal_8mhz_oscillator_tick,
  input  wire logic [pcs_pkg::NUM_SRC-1:0] ext_src_tick,
  // generic clocks
  output logic [pcs_pkg::NUM_MUX-1:0]      peripheral_generic_clock_q,
  output logic                             watchdog_generic_clock,
  // configuration port
  input  wire logic                        cfg_we,
  input  wire logic [3:0]                  cfg_addr,
  input  wire logic [15:0]                 cfg_wdata,
  output logic                             cfg_done_q,
  output logic                             cfg_err_q,
  // protection and debug
  input  wire logic                        periph_access_wp,
  input  wire logic                        cpu_debug_halted,
  input  wire logic                        debugger_access,
  // processor start
  output logic                             fetch_req,
  output logic [31:0]                      fetch_addr_q,
  input  wire logic                        fetch_ack,
  input  wire logic [31:0]                 fetch_rdata,
  output logic [31:0]                      init_sp_q,
  output logic [31:0]                      init_pc_q,
  output logic                             cpu_run_q,
  // I/O pins
  output logic [pcs_pkg::NUM_IO-1:0]       io_out_q,
  output logic [pcs_pkg::NUM_IO-1:0]       io_oe_q
);

  pcs_pkg::pcs_state_e state_q;
  pcs_pkg::pcs_state_e state_d;

  logic [pcs_pkg::SEL_W-1:0]  gen_src_q [pcs_pkg::NUM_GEN];
  logic [pcs_pkg::DIV_W-1:0]  gen_div_q [pcs_pkg::NUM_GEN];
  logic [pcs_pkg::NUM_GEN-1:0] gen_en_q;
  logic [pcs_pkg::NUM_GEN-1:0] gen_div_en_q;
  logic [pcs_pkg::NUM_GEN-1:0] gen_tick;
  logic [pcs_pkg::NUM_SRC-1:0] src_tick;
  logic [pcs_pkg::SEL_W-1:0]  mux_gen_q [pcs_pkg::NUM_MUX];
  logic [pcs_pkg::NUM_MUX-1:0] mux_en_q;
  logic                       hold;
  logic                       gen_rst;
  logic                       wr_ok;
  logic                       wr_blocked;

  // pick one tick out of an eight-wide vector
  function automatic logic pick_tick(input logic [7:0] v, input logic [pcs_pkg::SEL_W-1:0] i);
    pick_tick = v[i];
  endfunction

  // ----------------------------------------------------------------
  // startup sequence
  // ----------------------------------------------------------------
  assign hold    = (state_q == pcs_pkg::S_HOLD);
  assign gen_rst = rst || hold;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pcs_pkg::S_HOLD: begin
        if (power_stable) begin
          state_d = pcs_pkg::S_FSP;                           // see RL1
        end
      end
      pcs_pkg::S_FSP: begin
        if (fetch_ack) begin
          state_d = pcs_pkg::S_FPC;
        end
      end
      pcs_pkg::S_FPC: begin
        if (fetch_ack) begin
          state_d = pcs_pkg::S_RUN;
        end
      end
      pcs_pkg::S_RUN: begin
        state_d = pcs_pkg::S_RUN;
      end
      default: begin
        state_d = pcs_pkg::S_HOLD;
      end
    endcase
    if (!power_stable) begin
      state_d = pcs_pkg::S_HOLD;                              // see RL1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pcs_pkg::S_HOLD;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sys_rst_q <= 1'b1;
    end else if (ce) begin
      sys_rst_q <= (state_d == pcs_pkg::S_HOLD);              // see RL1
    end
  end

  // ----------------------------------------------------------------
  // initial vector fetch
  // ----------------------------------------------------------------
  assign fetch_req = (state_q == pcs_pkg::S_FSP) || (state_q == pcs_pkg::S_FPC);

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_addr_q <= pcs_pkg::RESET_ADDR;
      init_sp_q    <= '0;
      init_pc_q    <= '0;
      cpu_run_q    <= 1'b0;
    end else if (ce) begin
      if (hold) begin
        fetch_addr_q <= pcs_pkg::RESET_ADDR;                  // see RL7
        cpu_run_q    <= 1'b0;
      end else if (fetch_ack && state_q == pcs_pkg::S_FSP) begin
        init_sp_q    <= fetch_rdata;                          // see RL7
        fetch_addr_q <= pcs_pkg::RESET_ADDR + pcs_pkg::WORD_STEP;
      end else if (fetch_ack && state_q == pcs_pkg::S_FPC) begin
        init_pc_q    <= fetch_rdata;                          // see RL7
        cpu_run_q    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // see RL8 / RL9 / RL10 / RL11
  assign wr_ok      = cfg_we && power_manager_bus_clk_en && !hold &&
                      (!periph_access_wp || cpu_debug_halted || debugger_access);
  assign wr_blocked = cfg_we && power_manager_bus_clk_en && !hold && !wr_ok;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_done_q <= 1'b0;
      cfg_err_q  <= 1'b0;
    end else if (ce) begin
      cfg_done_q <= wr_ok;                                    // see RL8
      cfg_err_q  <= wr_blocked;                               // see RL9
    end
  end

  genvar g;
  generate
    for (g = 0; g < pcs_pkg::NUM_GEN; g++) begin : g_gcfg
      always_ff @(posedge clk) begin
        if (gen_rst) begin
          gen_src_q[g]    <= pcs_pkg::GEN0_SRC_RST;           // see RL2
          gen_div_q[g]    <= pcs_pkg::GEN0_DIV_RST;
          gen_en_q[g]     <= pcs_pkg::GEN_EN_RST[g];
          gen_div_en_q[g] <= pcs_pkg::GEN_DIV_RST[g];
        end else if (ce && wr_ok && cfg_addr == pcs_pkg::CFG_GEN_BASE + 4'(g)) begin
          gen_src_q[g]    <= cfg_wdata[pcs_pkg::F_SRC +: pcs_pkg::SEL_W];
          gen_div_q[g]    <= cfg_wdata[pcs_pkg::F_DIV +: pcs_pkg::DIV_W];
          gen_en_q[g]     <= cfg_wdata[pcs_pkg::F_EN];
          gen_div_en_q[g] <= cfg_wdata[pcs_pkg::F_DIVEN];
        end
      end

      pcs_gen u_gen (                                         // see RL12
        .clk      (clk),
        .rst      (gen_rst),
        .ce       (ce),
        .src_tick (pick_tick(src_tick, gen_src_q[g])),
        .enable   (gen_en_q[g]),
        .div_en   (gen_div_en_q[g]),
        .div      (gen_div_q[g]),
        .tick_q   (gen_tick[g])
      );
    end

    for (g = 0; g < pcs_pkg::NUM_MUX; g++) begin : g_mux
      always_ff @(posedge clk) begin
        if (gen_rst) begin
          mux_gen_q[g] <= '0;
          mux_en_q[g]  <= pcs_pkg::MUX_EN_RST[g];             // see RL5
        end else if (ce && wr_ok && cfg_addr == pcs_pkg::CFG_MUX_BASE + 4'(g)) begin
          mux_gen_q[g] <= cfg_wdata[pcs_pkg::F_SRC +: pcs_pkg::SEL_W];
          mux_en_q[g]  <= cfg_wdata[pcs_pkg::F_EN];
        end
      end

      always_ff @(posedge clk) begin
        if (gen_rst) begin
          peripheral_generic_clock_q[g] <= 1'b0;
        end else if (ce) begin
          peripheral_generic_clock_q[g] <= mux_en_q[g] &&     // see RL14
                                           pick_tick(gen_tick, mux_gen_q[g]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sources and system clocks
  // ----------------------------------------------------------------
  assign src_tick = {ext_src_tick[pcs_pkg::NUM_SRC-1:1], internal_8mhz_oscillator_tick};
  assign power_manager_clk_tick = gen_tick[0];                // see RL3
  assign sys_clk_tick           = gen_tick[0];                // see RL4
  assign watchdog_generic_clock = peripheral_generic_clock_q[pcs_pkg::WATCHDOG_MUX];

  // ----------------------------------------------------------------
  // I/O pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (gen_rst) begin
      io_out_q <= '0;
      io_oe_q  <= '0;                                         // see RL6
    end else if (ce && wr_ok && cfg_addr == pcs_pkg::CFG_IO) begin
      io_out_q <= cfg_wdata[pcs_pkg::F_IO_OUT +: pcs_pkg::NUM_IO];
      io_oe_q  <= cfg_wdata[pcs_pkg::F_IO_OE +: pcs_pkg::NUM_IO];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [3:0] osc_cnt_q;
  always_ff @(posedge clk) begin
    if (gen_rst || !gen_en_q[0]) begin
      osc_cnt_q <= '0;
    end else if (ce && gen_tick[0]) begin
      osc_cnt_q <= 4'(src_tick[gen_src_q[0]]);
    end else if (ce && src_tick[gen_src_q[0]]) begin
      osc_cnt_q <= osc_cnt_q + 4'h1;
    end
  end

  sequence s_sp_taken;
    ce && state_q == pcs_pkg::S_FSP && fetch_ack && power_stable;
  endsequence

  sequence s_pc_stage;
    state_q == pcs_pkg::S_FPC && fetch_addr_q == pcs_pkg::RESET_ADDR + pcs_pkg::WORD_STEP;
  endsequence

  a_hold_reset: assert property (!power_stable && ce |=> sys_rst_q && hold)      // see RL1
    else $error("reset not held while power unstable");

  a_gen0_ratio: assert property (                                                 // see RL2
    gen_tick[0] && gen_div_en_q[0] && $past(gen_div_q[0]) == pcs_pkg::GEN0_DIV_RST
    && $past(gen_div_en_q[0]) |-> $past(osc_cnt_q) == 4'(pcs_pkg::GEN0_DIV_RST - 1))
    else $error("generator 0 ratio is not the startup divide");

  a_mgr_clock: assert property ($past(ce) && power_manager_clk_tick                 // see RL3
    |-> sys_clk_tick && $past(src_tick[gen_src_q[0]]))                            // see RL4
    else $error("main or system clock not from generator 0");

  a_watchdog_only: assert property (hold && !rst |=> mux_en_q == pcs_pkg::MUX_EN_RST) // see RL5
    else $error("peripheral clocks not in startup state");

  a_io_tristate: assert property (hold |=> io_oe_q == '0)                         // see RL6
    else $error("pins driven during power-up");

  a_fetch_vec: assert property (s_sp_taken |=> s_pc_stage)                        // see RL7
    else $error("second vector word not fetched after first");

  a_fetch_zero: assert property (state_q == pcs_pkg::S_FSP |-> fetch_addr_q == pcs_pkg::RESET_ADDR) // see RL7
    else $error("first fetch not at reset address");

  a_bus_gate: assert property (ce && cfg_we && !power_manager_bus_clk_en |=> !cfg_done_q && !cfg_err_q) // see RL8
    else $error("write accepted with bus clock off");

  a_wp_block: assert property (ce && cfg_we && power_manager_bus_clk_en && !hold && periph_access_wp
    && !cpu_debug_halted && !debugger_access |=> cfg_err_q && !cfg_done_q)        // see RL9
    else $error("protected write not refused");

  a_debug_pass: assert property (ce && cfg_we && power_manager_bus_clk_en && !hold
    && (cpu_debug_halted || debugger_access) |=> cfg_done_q && !cfg_err_q)        // see RL10
    else $error("debug write blocked by protection");                            // see RL11

  a_mux_route: assert property (ce && !gen_rst && mux_en_q[1]                     // see RL14
    && pick_tick(gen_tick, mux_gen_q[1]) |=> peripheral_generic_clock_q[1])
    else $error("multiplexer lost its generator tick");

endmodule

// ### verif/pcs_flash_model.sv
/*
  Behavioural model of the flash and core side that answers the startup
  vector fetches, promptly or after a few wait cycles.
  Assumes fetch_req is a level held until fetch_ack, synchronous to clk.
*/
`timescale 1ns/1ps
module pcs_flash_model #(
  parameter logic [31:0] SP_WORD = 32'h2000_0FF0,
  parameter logic [31:0] PC_WORD = 32'h0000_0201
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // pacing
  input  wire logic        slow,
  // fetch port
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output logic             fetch_ack,
  output logic [31:0]      fetch_rdata
);
  int unsigned wait_q;

  // ----------------------------------------------------------------
  // vector store at the reset address
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_ack   <= 1'b0;
      fetch_rdata <= 32'h5A5A_A5A5;
      wait_q      <= 0;
    end else if (fetch_req && !fetch_ack && wait_q >= (slow ? 5 : 0)) begin
      fetch_ack   <= 1'b1;
      fetch_rdata <= (fetch_addr == 32'h0000_0000) ? SP_WORD :
                     (fetch_addr == 32'h0000_0004) ? PC_WORD : ~fetch_addr;
      wait_q      <= 0;
    end else begin
      // outside an answer the data lines keep changing
      fetch_ack   <= 1'b0;
      fetch_rdata <= ~fetch_rdata;
      wait_q      <= (fetch_req && !fetch_ack) ? wait_q + 1 : 0;
    end
  end
endmodule

// ### verif/pcs_top_tb.sv
/*
  Self-checking testbench for the startup clock block: reset hold, vector
  fetch, startup clocks, protected configuration, generator routing, power loss.
  Assumes pcs_pkg and the flash model are compiled first.
*/
`timescale 1ns/1ps
module pcs_top_tb;
  logic clk, rst, ce, power_stable, bus_en, osc, cfg_we, wp, halted, dbg, slow, src_on, clr;
  logic [7:0] ext;
  logic [3:0] cfg_addr;
  logic [15:0] cfg_wdata;
  logic sys_rst_q, mgr_tick, sys_tick, dog_clk, cfg_done_q, cfg_err_q;
  logic fetch_req, fetch_ack, cpu_run_q;
  logic [3:0] pgc_q;
  logic [31:0] fetch_addr_q, fetch_rdata, init_sp_q, init_pc_q;
  logic [7:0] io_out_q, io_oe_q;
  int num_errors, tests_run, ph, n_osc, n_e1, n_mgr, n_sys, n_dog;
  int n_mux [4];

  pcs_top dut (.clk(clk), .rst(rst), .ce(ce), .power_stable(power_stable),
    .power_manager_bus_clk_en(bus_en), .sys_rst_q(sys_rst_q), .power_manager_clk_tick(mgr_tick),
    .sys_clk_tick(sys_tick), .internal_8mhz_oscillator_tick(osc), .ext_src_tick(ext),
    .peripheral_generic_clock_q(pgc_q), .watchdog_generic_clock(dog_clk), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_done_q(cfg_done_q), .cfg_err_q(cfg_err_q),
    .periph_access_wp(wp), .cpu_debug_halted(halted), .debugger_access(dbg),
    .fetch_req(fetch_req), .fetch_addr_q(fetch_addr_q), .fetch_ack(fetch_ack),
    .fetch_rdata(fetch_rdata), .init_sp_q(init_sp_q), .init_pc_q(init_pc_q),
    .cpu_run_q(cpu_run_q), .io_out_q(io_out_q), .io_oe_q(io_oe_q));

  pcs_flash_model flash (.clk(clk), .rst(rst), .slow(slow), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr_q), .fetch_ack(fetch_ack), .fetch_rdata(fetch_rdata));

  // ----------------------------------------------------------------
  // clock, sources and tick counters
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    ph  <= ph + 1;
    osc <= src_on && (ph % 2 == 0);
    ext <= src_on ? {5'h00, (ph % 2 == 0), (ph % 3 == 0), 1'b0} : 8'h00;
    n_osc <= clr ? 0 : n_osc + int'(osc);
    n_e1  <= clr ? 0 : n_e1 + int'(ext[1]);
    n_mgr <= clr ? 0 : n_mgr + int'(mgr_tick);
    n_sys <= clr ? 0 : n_sys + int'(sys_tick);
    n_dog <= clr ? 0 : n_dog + int'(dog_clk);
    for (int i = 0; i < 4; i++) begin
      n_mux[i] <= clr ? 0 : n_mux[i] + int'(pgc_q[i]);
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_for(input string what, input bit run);
    int k;
    for (k = 0; k < 200 && (run ? cpu_run_q : fetch_req) !== 1'b1; k++) @(posedge clk) #1;
    if (k == 200) begin
      num_errors++;
      $display("Error %s expected 1 seen timeout", what);
      complete_run();
    end
  endtask

  // one source burst of 64 oscillator ticks, counters cleared first
  task automatic burst();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    src_on <= 1'b1;
    repeat (128) @(posedge clk);
    src_on <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic cfg_write(input logic [3:0] a, input logic [15:0] d, input logic done, input logic err);
    @(posedge clk) begin
      cfg_we    <= 1'b1;
      cfg_addr  <= a;
      cfg_wdata <= d;
    end
    @(posedge clk) cfg_we <= 1'b0;
    #1;
    check("cfg_done", cfg_done_q, done);
    check("cfg_err", cfg_err_q, err);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_hold();
    burst();
    check("hold reset", sys_rst_q, 1'b1);
    check("hold fetch", fetch_req, 1'b0);
    check("hold ticks", n_mgr + n_dog, 0);
    check("hold oe", io_oe_q, 8'h00);
    cfg_write(pcs_pkg::CFG_IO, 16'hFFFF, 1'b0, 1'b0);
    $display("test hold done");
  endtask

  task automatic test_fetch(input logic pace);
    slow <= pace;
    @(posedge clk) power_stable <= 1'b1;
    wait_for("fetch_req", 1'b0);
    check("release", sys_rst_q, 1'b0);
    check("first addr", fetch_addr_q, 0);
    check("io after power", io_oe_q, 8'h00);
    wait_for("cpu_run", 1'b1);
    check("sp", init_sp_q, 32'h2000_0FF0);
    check("pc", init_pc_q, 32'h0000_0201);
    check("req done", fetch_req, 1'b0);
    $display("test fetch done");
  endtask

  task automatic test_startup_clocks();
    burst();
    check("osc ticks", n_osc, 64);
    check("gen0 ticks", n_mgr, 8);
    check("mgr ticks", n_mgr, n_osc / 8);
    check("sys undivided", n_sys, 8);
    check("watchdog ticks", n_dog, 8);
    check("mux0 is watchdog", n_mux[0], n_dog);
    check("other muxes", n_mux[1] + n_mux[2] + n_mux[3], 0);
    $display("test startup clocks done");
  endtask

  task automatic test_protect();
    bus_en <= 1'b0;
    cfg_write(pcs_pkg::CFG_IO, 16'hFFFF, 1'b0, 1'b0);
    bus_en <= 1'b1;
    wp     <= 1'b1;
    cfg_write(pcs_pkg::CFG_IO, 16'hFF00, 1'b0, 1'b1);
    check("refused oe", io_oe_q, 8'h00);
    halted <= 1'b1;
    cfg_write(pcs_pkg::CFG_IO, 16'h0F5A, 1'b1, 1'b0);
    check("halted oe", io_oe_q, 8'h0F);
    check("halted out", io_out_q, 8'h5A);
    halted <= 1'b0;
    dbg    <= 1'b1;
    cfg_write(pcs_pkg::CFG_IO, 16'hF0A5, 1'b1, 1'b0);
    check("debugger oe", io_oe_q, 8'hF0);
    dbg <= 1'b0;
    wp  <= 1'b0;
    $display("test protect done");
  endtask

  task automatic test_routing();
    cfg_write(pcs_pkg::CFG_GEN_BASE + 4'h1, 16'h0009, 1'b1, 1'b0);
    cfg_write(pcs_pkg::CFG_GEN_BASE + 4'h7, 16'h021A, 1'b1, 1'b0);
    cfg_write(pcs_pkg::CFG_MUX_BASE + 4'h1, 16'h0009, 1'b1, 1'b0);
    cfg_write(pcs_pkg::CFG_MUX_BASE + 4'h2, 16'h0009, 1'b1, 1'b0);
    cfg_write(pcs_pkg::CFG_MUX_BASE + 4'h3, 16'h000F, 1'b1, 1'b0);
    burst();
    check("direct mux1", n_mux[1], n_e1);
    check("direct mux2", n_mux[2], n_e1);
    check("div2 mux3", n_mux[3], 32);
    check("watchdog kept", n_dog, 8);
    $display("test routing done");
  endtask

  task automatic test_power_loss();
    @(posedge clk) power_stable <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("loss reset", sys_rst_q, 1'b1);
    check("loss oe", io_oe_q, 8'h00);
    check("loss run", cpu_run_q, 1'b0);
    test_fetch(1'b1);
    burst();
    check("restart mux3", n_mux[3], 0);
    check("restart gen0", n_mgr, 8);
    $display("test power loss done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, power_stable, bus_en} = 4'hD;
    {cfg_we, wp, halted, dbg, slow, src_on, clr} = 7'h01;
    cfg_addr = 4'h0;
    cfg_wdata = 16'h0000;
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    test_hold();
    test_fetch(1'b0);
    test_startup_clocks();
    test_protect();
    test_routing();
    test_power_loss();
    complete_run();
  end
endmodule
